// [src/power_mode_params.svh]
`ifndef POWER_MODE_PARAMS_SVH
`define POWER_MODE_PARAMS_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS 8
`define ACTIVE_WINDOW_NS 9000000
`define ACTIVE_WINDOW_CYCLES (`ACTIVE_WINDOW_NS / `CLK_PERIOD_NS)
`define BLANK_NS 100000
`define BLANK_CYCLES (`BLANK_NS / `CLK_PERIOD_NS)
`define WAKE_FILT_NS 1000
`define WAKE_FILT_CYCLES ((`WAKE_FILT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ----------------------------------------------------------------------------
// Register map
// ----------------------------------------------------------------------------
`define REG_ADDR_W 7
`define REG_DATA_W 16
`define REG_SLOPE_CONFIG_ADDR 7'h3f
`define REG_STATUS_ADDR 7'h40
`define SLOPE_CONFIG_RESET 16'h0000
`define SLOPE_RESERVE_BOOST_BIT 8
`define SLOPE_SYNC_BOOST_BIT 9
`define SLOPE_SENSOR_BUCK_BIT 10

// ----------------------------------------------------------------------------
// Reset levels
// ----------------------------------------------------------------------------
`define SYNC_LEVEL_DEFAULT 1'h0
`define SENSOR_LEVEL_DEFAULT 1'h0

`endif

// [src/power_mode_pkg.sv]
package power_mode_pkg;

    typedef enum logic [2:0] {
        POWER_OFF    = 3'h0,
        WAKE_MONITOR = 3'h1,
        AWAKE        = 3'h2,
        STARTUP      = 3'h3,
        RUN          = 3'h4,
        PM_SHUTDOWN  = 3'h5,
        ER_DRAIN     = 3'h6,
        VIN_BLANK    = 3'h7
    } power_state_t;

    typedef struct packed {
        logic sleep;
        logic shutdown;
        logic sensorBuckOff;
        logic chargeOn;
        logic chargeOff;
        logic dischargeOn;
        logic dischargeOff;
        logic sensorLevelWrite;
        logic sensorLevel9v;
    } power_cmd_t;

    typedef struct packed {
        logic batteryGood;
        logic inputMin;
        logic inputGood;
        logic syncOverReg;
    } monitor_t;

    typedef struct packed {
        logic syncBoostGood;
        logic sensorBuckGood;
        logic systemBuckGood;
    } reg_good_t;

    typedef struct packed {
        logic internalRegs;
        logic reserveBoost;
        logic syncPulseBoost;
        logic sensorBuck;
        logic systemBuck;
    } supply_en_t;

endpackage

// [src/wake_filter.sv]
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"

module wake_filter #(
    parameter int unsigned FILT_CYCLES = `WAKE_FILT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wakeRaw,
    output logic wakeFilt
);

    logic filt_q;
    logic filt_d;
    logic [31:0] cnt_q;
    logic [31:0] cnt_d;

    // The output only follows the input after it has held the new level for
    // the whole filter time, so a glitch shorter than that is dropped.
    always_comb
    begin
        filt_d = filt_q;
        cnt_d = 32'h0;
        if (wakeRaw != filt_q)
        begin
            if (cnt_q >= FILT_CYCLES - 1)
            begin
                filt_d = wakeRaw;
            end
            else
            begin
                cnt_d = cnt_q + 32'h1;
            end
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            filt_q <= 1'h0;
            cnt_q <= 32'h0;
        end
        else
        begin
            filt_q <= filt_d;
            cnt_q <= cnt_d;
        end
    end

    assign wakeFilt = filt_q;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_filter_hold: assert property ($changed(filt_q) |-> $past(cnt_q) == FILT_CYCLES - 1)
        else $error("Wake filter changed before the filter time elapsed.");

endmodule
`default_nettype wire

// [src/power_mode_sequencer.sv]
`timescale 1ns/1ps
`default_nettype none
`include "power_mode_params.svh"

module power_mode_sequencer #(
    parameter int unsigned ACTIVE_WINDOW_CYCLES = `ACTIVE_WINDOW_CYCLES,
    parameter int unsigned BLANK_CYCLES = `BLANK_CYCLES,
    parameter int unsigned WAKE_FILT_CYCLES = `WAKE_FILT_CYCLES
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wakeIn,
    input wire power_mode_pkg::monitor_t monitors,
    input wire power_mode_pkg::reg_good_t regGood,
    input wire power_mode_pkg::power_cmd_t cmd,
    input wire logic supplyLevelSelect,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [`REG_ADDR_W-1:0] regAddr,
    input wire logic [`REG_DATA_W-1:0] regWdata,
    output logic [`REG_DATA_W-1:0] regRdata,
    output var power_mode_pkg::supply_en_t supplyEn,
    output logic sysResetN,
    output logic crossoverSwitchOn,
    output logic crossoverActive,
    output logic chargeEn,
    output logic dischargeEn,
    output logic sensorLevel9v,
    output logic systemLevel5v,
    output logic syncLevelHigh,
    output logic [2:0] fastSlope,
    output logic functionsEnable,
    output var power_mode_pkg::power_state_t powerState
);

    // ------------------------------------------------------------------------
    // Wake input filter
    // ------------------------------------------------------------------------
    logic wakeFilt;

    wake_filter #(
        .FILT_CYCLES(WAKE_FILT_CYCLES)
    ) u_wake_filter (
        .clk(clk),
        .rst(rst),
        .wakeRaw(wakeIn),
        .wakeFilt(wakeFilt)
    );

    // ------------------------------------------------------------------------
    // Mode state machine
    // ------------------------------------------------------------------------
    power_mode_pkg::power_state_t state_q;
    power_mode_pkg::power_state_t state_d;
    logic [31:0] windowCnt_q;
    logic [31:0] windowCnt_d;
    logic [31:0] blankCnt_q;
    logic [31:0] blankCnt_d;
    logic windowOpen;
    logic isActive;
    logic isPassive;
    logic powered;
    logic supplyLoss;
    logic sysResetN_q;

    assign windowOpen = windowCnt_q < ACTIVE_WINDOW_CYCLES;
    assign isActive = (state_q == power_mode_pkg::STARTUP) || (state_q == power_mode_pkg::RUN);
    assign isPassive = (state_q == power_mode_pkg::PM_SHUTDOWN) || (state_q == power_mode_pkg::ER_DRAIN)
        || (state_q == power_mode_pkg::VIN_BLANK);
    assign powered = isActive || isPassive;
    assign supplyLoss = !monitors.inputMin || !monitors.batteryGood;

    always_comb
    begin
        state_d = state_q;
        // The window counter is cleared in the awake state, which every entry
        // into the startup state passes through.
        if (state_q == power_mode_pkg::AWAKE)
        begin
            windowCnt_d = 32'h0;
        end
        else if (isActive && windowOpen)
        begin
            windowCnt_d = windowCnt_q + 32'h1;
        end
        else
        begin
            windowCnt_d = windowCnt_q;
        end
        blankCnt_d = (state_q == power_mode_pkg::VIN_BLANK) ? blankCnt_q + 32'h1 : 32'h0;
        unique case (state_q)
            power_mode_pkg::POWER_OFF:
            begin
                if (wakeIn)
                begin
                    state_d = power_mode_pkg::WAKE_MONITOR;
                end
            end
            power_mode_pkg::WAKE_MONITOR:
            begin
                if (wakeFilt)
                begin
                    state_d = power_mode_pkg::AWAKE;
                end
            end
            power_mode_pkg::AWAKE:
            begin
                if (!wakeFilt)
                begin
                    state_d = power_mode_pkg::WAKE_MONITOR;
                end
                else if (monitors.inputMin)
                begin
                    state_d = power_mode_pkg::STARTUP;
                end
            end
            power_mode_pkg::STARTUP, power_mode_pkg::RUN:
            begin
                if (windowOpen && !wakeFilt)
                begin
                    state_d = power_mode_pkg::WAKE_MONITOR;
                end
                else if (supplyLoss)
                begin
                    state_d = power_mode_pkg::VIN_BLANK;
                end
                else if (state_q == power_mode_pkg::STARTUP)
                begin
                    if (sysResetN_q)
                    begin
                        state_d = power_mode_pkg::RUN;
                    end
                end
                else if (cmd.shutdown)
                begin
                    state_d = power_mode_pkg::PM_SHUTDOWN;
                end
                // A sleep request counts only once the wake line has dropped
                // after the early window.
                else if (cmd.sleep && !wakeFilt && !windowOpen)
                begin
                    state_d = power_mode_pkg::PM_SHUTDOWN;
                end
            end
            power_mode_pkg::VIN_BLANK:
            begin
                if (!supplyLoss)
                begin
                    state_d = power_mode_pkg::RUN;
                end
                else if (blankCnt_q >= BLANK_CYCLES - 1)
                begin
                    state_d = monitors.inputGood ? power_mode_pkg::PM_SHUTDOWN : power_mode_pkg::ER_DRAIN;
                end
            end
            power_mode_pkg::PM_SHUTDOWN:
            begin
                if (cmd.sensorBuckOff)
                begin
                    state_d = power_mode_pkg::POWER_OFF;
                end
            end
            power_mode_pkg::ER_DRAIN:
            begin
                // Only the internal power-on reset leaves this state.
                state_d = power_mode_pkg::ER_DRAIN;
            end
        endcase
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            state_q <= power_mode_pkg::POWER_OFF;
            windowCnt_q <= 32'h0;
            blankCnt_q <= 32'h0;
        end
        else
        begin
            state_q <= state_d;
            windowCnt_q <= windowCnt_d;
            blankCnt_q <= blankCnt_d;
        end
    end

    // ------------------------------------------------------------------------
    // Supply sequencing and reserve control
    // ------------------------------------------------------------------------
    power_mode_pkg::supply_en_t supplyEn_q;
    power_mode_pkg::supply_en_t supplyEn_d;
    logic sysResetN_d;
    logic crossover_q;
    logic crossover_d;
    logic chargeEn_q;
    logic chargeEn_d;
    logic dischargeEn_q;
    logic dischargeEn_d;
    logic sensorLevel_q;
    logic sensorLevel_d;
    logic systemLevel_q;
    logic functionsEn_q;

    always_comb
    begin
        supplyEn_d.internalRegs = state_q != power_mode_pkg::POWER_OFF;
        supplyEn_d.reserveBoost = isActive;
        supplyEn_d.syncPulseBoost = powered && !monitors.syncOverReg;
        // The bucks latch on once started so a sync boost pause at high
        // battery does not drop the downstream rails.
        supplyEn_d.sensorBuck = powered && (supplyEn_q.sensorBuck || regGood.syncBoostGood);
        supplyEn_d.systemBuck = powered && supplyEn_q.sensorBuck
            && (supplyEn_q.systemBuck || regGood.sensorBuckGood);
        sysResetN_d = powered && supplyEn_q.systemBuck && regGood.systemBuckGood;
        crossover_d = (state_q == power_mode_pkg::PM_SHUTDOWN) || (state_q == power_mode_pkg::ER_DRAIN)
            || (powered && !monitors.batteryGood);
        chargeEn_d = chargeEn_q;
        if (!isActive)
        begin
            chargeEn_d = 1'h0;
        end
        else if (cmd.chargeOff)
        begin
            chargeEn_d = 1'h0;
        end
        else if (cmd.chargeOn && sysResetN_q && !dischargeEn_q)
        begin
            chargeEn_d = 1'h1;
        end
        dischargeEn_d = dischargeEn_q;
        if (state_q != power_mode_pkg::PM_SHUTDOWN)
        begin
            dischargeEn_d = 1'h0;
        end
        else if (cmd.dischargeOff)
        begin
            dischargeEn_d = 1'h0;
        end
        else if (cmd.dischargeOn)
        begin
            dischargeEn_d = 1'h1;
        end
        sensorLevel_d = cmd.sensorLevelWrite ? cmd.sensorLevel9v : sensorLevel_q;
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            supplyEn_q <= '0;
            sysResetN_q <= 1'h0;
            crossover_q <= 1'h0;
            chargeEn_q <= 1'h0;
            dischargeEn_q <= 1'h0;
            sensorLevel_q <= `SENSOR_LEVEL_DEFAULT;
            systemLevel_q <= 1'h0;
            functionsEn_q <= 1'h0;
        end
        else
        begin
            supplyEn_q <= supplyEn_d;
            sysResetN_q <= sysResetN_d;
            crossover_q <= crossover_d;
            chargeEn_q <= chargeEn_d;
            dischargeEn_q <= dischargeEn_d;
            sensorLevel_q <= sensorLevel_d;
            systemLevel_q <= supplyLevelSelect;
            functionsEn_q <= powered;
        end
    end

    // ------------------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------------------
    logic [`REG_DATA_W-1:0] slope_q;
    logic [`REG_DATA_W-1:0] slope_d;
    logic [`REG_DATA_W-1:0] rdata_q;
    logic [`REG_DATA_W-1:0] rdata_d;

    always_comb
    begin
        slope_d = slope_q;
        if (regWrite && (regAddr == `REG_SLOPE_CONFIG_ADDR))
        begin
            slope_d = regWdata;
        end
        rdata_d = rdata_q;
        if (regRead)
        begin
            unique case (regAddr)
                `REG_SLOPE_CONFIG_ADDR: rdata_d = slope_q;
                `REG_STATUS_ADDR: rdata_d = {7'h0, systemLevel_q, sensorLevel_q, dischargeEn_q, chargeEn_q,
                    crossover_q, sysResetN_q, state_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            slope_q <= `SLOPE_CONFIG_RESET;
            rdata_q <= 16'h0000;
        end
        else
        begin
            slope_q <= slope_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign regRdata = rdata_q;
    assign supplyEn = supplyEn_q;
    assign sysResetN = sysResetN_q;
    assign crossoverSwitchOn = crossover_q;
    assign crossoverActive = crossover_q;
    assign chargeEn = chargeEn_q;
    assign dischargeEn = dischargeEn_q;
    assign sensorLevel9v = sensorLevel_q;
    assign systemLevel5v = systemLevel_q;
    assign syncLevelHigh = `SYNC_LEVEL_DEFAULT;
    assign fastSlope = {slope_q[`SLOPE_SENSOR_BUCK_BIT], slope_q[`SLOPE_SYNC_BOOST_BIT],
        slope_q[`SLOPE_RESERVE_BOOST_BIT]};
    assign functionsEnable = functionsEn_q;
    assign powerState = state_q;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_reset_release: assert property ($rose(sysResetN_q) |-> $past(regGood.systemBuckGood) && $past(powered))
        else $error("System reset released without buck regulation.");
    a_reset_reassert: assert property ((!powered || !regGood.systemBuckGood) |=> !sysResetN_q)
        else $error("System reset not reasserted.");
    a_off_supplies: assert property (state_q == power_mode_pkg::POWER_OFF |=> supplyEn_q == '0)
        else $error("Supply enabled in power-off.");
    a_sleep_supplies: assert property ((state_q == power_mode_pkg::WAKE_MONITOR || state_q == power_mode_pkg::AWAKE)
        |=> supplyEn_q.internalRegs && !supplyEn_q.reserveBoost && !supplyEn_q.sensorBuck && !supplyEn_q.systemBuck)
        else $error("Wrong supplies in sleep.");
    a_buck_order: assert property ($rose(supplyEn_q.systemBuck) |-> supplyEn_q.sensorBuck
        && $past(regGood.sensorBuckGood))
        else $error("System buck started out of order.");
    a_early_wake: assert property (isActive && windowOpen && !wakeFilt |=> state_q == power_mode_pkg::WAKE_MONITOR)
        else $error("Early wake low did not return to sleep.");
    a_sleep_ignored: assert property (state_q == power_mode_pkg::RUN && wakeFilt && !cmd.shutdown
        |=> state_q != power_mode_pkg::PM_SHUTDOWN)
        else $error("Sleep executed while wake high.");
    a_vin_drop: assert property (state_q == power_mode_pkg::RUN && supplyLoss && !(windowOpen && !wakeFilt)
        |=> state_q == power_mode_pkg::VIN_BLANK)
        else $error("Input loss did not leave active mode.");
    a_passive_off: assert property (isPassive |=> !chargeEn_q && !supplyEn_q.reserveBoost)
        else $error("Charge or reserve boost on in passive.");
    a_crossover_on: assert property (state_q == power_mode_pkg::ER_DRAIN |=> crossoverActive && crossoverSwitchOn)
        else $error("Crossover not active in reserve state.");
    a_slope_write: assert property (regWrite && regAddr == `REG_SLOPE_CONFIG_ADDR
        |=> fastSlope == $past(regWdata[10:8]))
        else $error("Fast-slope bits not updated.");
    a_sync_over: assert property ($past(monitors.syncOverReg) |-> !supplyEn_q.syncPulseBoost)
        else $error("Sync boost on above regulation point.");
    a_func_block: assert property (!powered |=> !functionsEnable)
        else $error("Functions enabled in off or sleep.");

    c_run_reached: cover property (state_q == power_mode_pkg::STARTUP ##1 state_q == power_mode_pkg::RUN);
    c_shutdown_off: cover property (state_q == power_mode_pkg::PM_SHUTDOWN ##1 state_q == power_mode_pkg::POWER_OFF);
    c_reserve_entry: cover property (state_q == power_mode_pkg::VIN_BLANK ##1 state_q == power_mode_pkg::ER_DRAIN);
    c_early_return: cover property (isActive ##1 state_q == power_mode_pkg::WAKE_MONITOR);

endmodule
`default_nettype wire

// [verif/power_mode_partner.sv]
`timescale 1ns/1ps
`default_nettype none
module power_mode_partner (
    input wire logic clk,
    input wire logic rst,
    input wire power_mode_pkg::supply_en_t supplyEn,
    input wire logic slow,
    output var power_mode_pkg::reg_good_t regGood,
    output var power_mode_pkg::power_cmd_t cmd
);
    logic [3:0] lag;

    initial cmd = '0;

    // Goods trail their enables; slow mode only refreshes them every seventh cycle.
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            lag <= 4'h0;
            regGood <= '0;
        end
        else
        begin
            lag <= (lag != 4'h0) ? lag - 4'h1 : (slow ? 4'h6 : 4'h0);
            if (lag == 4'h0)
                regGood <= {supplyEn.syncPulseBoost, supplyEn.sensorBuck, supplyEn.systemBuck};
        end
    end

    task automatic send(input logic [8:0] m);
        @(posedge clk);
        cmd <= m;
        @(posedge clk);
        cmd <= '0;
    endtask
endmodule
`default_nettype wire

// [verif/power_mode_sequencer_tb_top.sv]
`timescale 1ns/1ps
`default_nettype none
module power_mode_sequencer_tb_top;
    localparam int WIN = 200;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic wakeIn = 1'b0;
    logic slow = 1'b0;
    logic supplyLevelSelect = 1'b0;
    logic regWrite = 1'b0;
    logic regRead = 1'b0;
    logic [6:0] regAddr = 7'h00;
    logic [15:0] regWdata = 16'h0000;
    logic [15:0] regRdata;
    power_mode_pkg::monitor_t monitors = 4'he;
    power_mode_pkg::reg_good_t regGood;
    power_mode_pkg::power_cmd_t cmd;
    power_mode_pkg::supply_en_t supplyEn;
    power_mode_pkg::power_state_t powerState;
    logic sysResetN, crossoverSwitchOn, crossoverActive, chargeEn, dischargeEn;
    logic sensorLevel9v, systemLevel5v, syncLevelHigh, functionsEnable;
    logic [2:0] fastSlope;
    int numErrors = 0;
    int samplesChecked = 0;

    always #4 clk = ~clk;

    power_mode_sequencer #(.ACTIVE_WINDOW_CYCLES(WIN), .BLANK_CYCLES(10), .WAKE_FILT_CYCLES(4))
    power_mode_sequencer_inst (.clk(clk), .rst(rst), .wakeIn(wakeIn), .monitors(monitors),
        .regGood(regGood), .cmd(cmd), .supplyLevelSelect(supplyLevelSelect), .regWrite(regWrite),
        .regRead(regRead), .regAddr(regAddr), .regWdata(regWdata), .regRdata(regRdata),
        .supplyEn(supplyEn), .sysResetN(sysResetN), .crossoverSwitchOn(crossoverSwitchOn),
        .crossoverActive(crossoverActive), .chargeEn(chargeEn), .dischargeEn(dischargeEn),
        .sensorLevel9v(sensorLevel9v), .systemLevel5v(systemLevel5v), .syncLevelHigh(syncLevelHigh),
        .fastSlope(fastSlope), .functionsEnable(functionsEnable), .powerState(powerState));

    power_mode_partner power_mode_partner_inst (.clk(clk), .rst(rst), .supplyEn(supplyEn),
        .slow(slow), .regGood(regGood), .cmd(cmd));

    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samplesChecked++;
        if (got !== exp)
        begin
            numErrors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic waitState(input power_mode_pkg::power_state_t s, input int lim);
        int n = 0;
        while (powerState !== s && n < lim)
        begin
            tick(1);
            n++;
        end
        chk("powerState", 16'(s), 16'(powerState));
    endtask

    task automatic doReset();
        @(posedge clk);
        rst <= 1'b1;
        wakeIn <= 1'b0;
        monitors <= 4'he;
        slow <= 1'b0;
        tick(5);
        @(posedge clk);
        rst <= 1'b0;
        tick(1);
    endtask

    task automatic regAccess(input logic wr, input logic [6:0] a, input logic [15:0] d);
        @(posedge clk);
        regWrite <= wr;
        regRead <= ~wr;
        regAddr <= a;
        regWdata <= d;
        @(posedge clk);
        regWrite <= 1'b0;
        regRead <= 1'b0;
        tick(1);
    endtask

    task automatic powerUp();
        @(posedge clk);
        wakeIn <= 1'b1;
        waitState(power_mode_pkg::STARTUP, 40);
        tick(1);
        chk("boostsOnly", 16'h0038, 16'({supplyEn, sysResetN}));
        waitState(power_mode_pkg::RUN, 80);
        chk("runOutputs", 16'h00fe, 16'({supplyEn, sysResetN, functionsEnable, crossoverActive}));
    endtask

    task automatic endOfTest();
        $display("comparisons %0d mismatches %0d", samplesChecked, numErrors);
        if (numErrors == 0 && samplesChecked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic glitchTest();
        doReset();
        chk("resetOutputs", 16'h0000, 16'({supplyEn, sysResetN, functionsEnable, powerState}));
        @(posedge clk);
        wakeIn <= 1'b1;
        @(posedge clk);
        @(posedge clk);
        wakeIn <= 1'b0;
        tick(12);
        chk("glitchState", 16'(power_mode_pkg::WAKE_MONITOR), 16'(powerState));
        chk("sleepSupplies", 16'h0020, 16'({supplyEn, functionsEnable}));
    endtask

    task automatic earlyWakeTest();
        doReset();
        powerUp();
        tick(100);
        @(posedge clk);
        wakeIn <= 1'b0;
        waitState(power_mode_pkg::WAKE_MONITOR, 20);
        @(posedge clk);
        slow <= 1'b1;
        powerUp();
        tick(150);
        @(posedge clk);
        wakeIn <= 1'b0;
        waitState(power_mode_pkg::WAKE_MONITOR, 20);
    endtask

    task automatic lateSleepTest();
        doReset();
        powerUp();
        power_mode_partner_inst.send(9'h020);
        tick(2);
        chk("chargeEn", 16'h0001, 16'(chargeEn));
        power_mode_partner_inst.send(9'h010);
        tick(2);
        chk("chargeOff", 16'h0000, 16'(chargeEn));
        // Charge is switched back on so that only passive mode can clear it below.
        power_mode_partner_inst.send(9'h020);
        tick(WIN);
        power_mode_partner_inst.send(9'h100);
        tick(3);
        chk("sleepWakeHigh", 16'(power_mode_pkg::RUN), 16'(powerState));
        @(posedge clk);
        wakeIn <= 1'b0;
        tick(10);
        chk("lateWakeLow", 16'(power_mode_pkg::RUN), 16'(powerState));
        power_mode_partner_inst.send(9'h100);
        waitState(power_mode_pkg::PM_SHUTDOWN, 4);
        tick(2);
        chk("passiveOut", 16'h000c, 16'({crossoverSwitchOn, crossoverActive, chargeEn, supplyEn.reserveBoost}));
        power_mode_partner_inst.send(9'h008);
        tick(2);
        chk("dischargeEn", 16'h0001, 16'(dischargeEn));
        power_mode_partner_inst.send(9'h004);
        tick(2);
        chk("dischargeOff", 16'h0000, 16'(dischargeEn));
        power_mode_partner_inst.send(9'h040);
        waitState(power_mode_pkg::POWER_OFF, 4);
    endtask

    task automatic vinLossTest();
        doReset();
        powerUp();
        @(posedge clk);
        monitors <= 4'h8;
        waitState(power_mode_pkg::VIN_BLANK, 4);
        waitState(power_mode_pkg::ER_DRAIN, 20);
        tick(2);
        chk("erOutputs", 16'h0006, 16'({crossoverSwitchOn, crossoverActive, supplyEn.reserveBoost}));
    endtask

    task automatic batteryLossTest();
        doReset();
        powerUp();
        @(posedge clk);
        monitors <= 4'h6;
        waitState(power_mode_pkg::VIN_BLANK, 4);
        chk("lossCross", 16'h0001, 16'(crossoverActive));
        @(posedge clk);
        monitors <= 4'he;
        waitState(power_mode_pkg::RUN, 4);
        chk("lossCrossOff", 16'h0000, 16'(crossoverActive));
        @(posedge clk);
        monitors <= 4'h6;
        waitState(power_mode_pkg::PM_SHUTDOWN, 20);
    endtask

    task automatic regTest();
        doReset();
        powerUp();
        regAccess(1'b1, 7'h3f, 16'h0700);
        chk("fastSlope", 16'h0007, 16'(fastSlope));
        regAccess(1'b0, 7'h3f, 16'h0000);
        chk("slopeRead", 16'h0700, regRdata);
        regAccess(1'b1, 7'h3f, 16'h0200);
        regAccess(1'b1, 7'h12, 16'hffff);
        chk("fastSlopeSync", 16'h0002, 16'(fastSlope));
        regAccess(1'b0, 7'h12, 16'h0000);
        chk("unmappedRead", 16'h0000, regRdata);
        regAccess(1'b0, 7'h40, 16'h0000);
        chk("statusRead", 16'h000c, regRdata);
        chk("syncLevelHigh", 16'h0000, 16'(syncLevelHigh));
        @(posedge clk);
        supplyLevelSelect <= 1'b1;
        tick(2);
        chk("systemLevel5v", 16'h0001, 16'(systemLevel5v));
        power_mode_partner_inst.send(9'h003);
        tick(2);
        chk("sensorLevel9v", 16'h0001, 16'(sensorLevel9v));
        @(posedge clk);
        monitors <= 4'hf;
        tick(3);
        chk("syncOverReg", 16'h0000, 16'(supplyEn.syncPulseBoost));
        power_mode_partner_inst.send(9'h080);
        waitState(power_mode_pkg::PM_SHUTDOWN, 4);
        tick(2);
        chk("shutdownCross", 16'h0001, 16'(crossoverActive));
    endtask

    initial
    begin
        glitchTest();
        earlyWakeTest();
        lateSleepTest();
        vinLossTest();
        batteryLossTest();
        regTest();
        endOfTest();
    end

    // A hang past more than ten times the expected run length ends the test as failed.
    initial
    begin
        #80000;
        numErrors++;
        endOfTest();
    end
endmodule
`default_nettype wire
